// *** core/t16cc_compare_chan.sv ***
// one compare channel: buffer, active compare value, flag and output bit
// assumes tick, block and update strobes already qualified by the caller
`timescale 1ns/10ps
module t16cc_compare_chan (
    input wire logic clock_i,
    input wire logic arst_n_i,
    input wire t16cc_pkg::t16cc_chan_ctl_t ctl_i,
    input wire logic [15:0] counter_i,
    input wire logic wr_i,
    input wire logic [15:0] wr_data_i,
    input wire logic flag_clr_i,
    output logic [15:0] value_o,
    output logic [15:0] active_o,
    output logic flag_o,
    output logic out_bit_o
);
    logic [15:0] buf_reg;
    logic [15:0] active_reg;
    logic flag_reg;
    logic out_reg;
    logic hit;

    // full-width match sampled on the timer tick, dropped after a counter write
    assign hit = ctl_i.tick && !ctl_i.blk && (counter_i == active_reg);

    // buffer mirrors every write so readback is the same in all modes
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            buf_reg <= t16cc_pkg::VAL_RST;
        end else if (wr_i) begin
            buf_reg <= wr_data_i;
        end
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            active_reg <= t16cc_pkg::VAL_RST;
        end else if (wr_i && !ctl_i.pwm) begin
            active_reg <= wr_data_i;
        end else if (ctl_i.pwm && ctl_i.upd) begin
            active_reg <= buf_reg;
        end
    end

    // set beats clear
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            flag_reg <= 1'b0;
        end else if (hit) begin
            flag_reg <= 1'b1;
        end else if (flag_clr_i) begin
            flag_reg <= 1'b0;
        end
    end

    // no mode term in the hold path, so a mode change leaves the bit alone
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            out_reg <= 1'b0;
        end else if (hit || (ctl_i.frc && !ctl_i.pwm)) begin
            out_reg <= t16cc_pkg::apply_action(ctl_i.action, out_reg);
        end
    end

    assign value_o = buf_reg;
    assign active_o = active_reg;
    assign flag_o = flag_reg;
    assign out_bit_o = out_reg;

    property p_hit_flag;
        @(posedge clock_i) disable iff (!arst_n_i)
        (ctl_i.tick && !ctl_i.blk && counter_i == active_o) |=> flag_o;
    endproperty
    a_hit_flag: assert property (p_hit_flag) else $error("match did not set flag");

    property p_blk;
        @(posedge clock_i) disable iff (!arst_n_i)
        (ctl_i.tick && ctl_i.blk && !flag_o) |=> !flag_o;
    endproperty
    a_blk: assert property (p_blk) else $error("blocked match set flag");

    property p_frc;
        @(posedge clock_i) disable iff (!arst_n_i)
        (ctl_i.frc && !ctl_i.tick && !flag_o) |=> !flag_o;
    endproperty
    a_frc: assert property (p_frc) else $error("force set the flag");

    property p_buf;
        @(posedge clock_i) disable iff (!arst_n_i)
        (wr_i && ctl_i.pwm && !ctl_i.upd) |=> $stable(active_o) && value_o == $past(wr_data_i);
    endproperty
    a_buf: assert property (p_buf) else $error("buffered write hit active");

    property p_upd;
        @(posedge clock_i) disable iff (!arst_n_i)
        (ctl_i.pwm && ctl_i.upd) |=> active_o == $past(value_o);
    endproperty
    a_upd: assert property (p_upd) else $error("buffer not transferred");

    property p_direct;
        @(posedge clock_i) disable iff (!arst_n_i)
        (wr_i && !ctl_i.pwm) |=> active_o == $past(wr_data_i);
    endproperty
    a_direct: assert property (p_direct) else $error("direct write lost");
endmodule

// *** core/t16cc_noise_filter.sv ***
// four-sample agreement filter on the system clock with bypass
// assumes a synchronised input; bypass path keeps the same single flop
`timescale 1ns/10ps
module t16cc_noise_filter #(
    parameter int SAMPLES = t16cc_pkg::FILT_SAMPLES
) (
    input wire logic clock_i,
    input wire logic arst_n_i,
    input wire logic din_i,
    input wire logic enable_i,
    output logic dout_o
);
    logic [SAMPLES-1:0] hist_reg;
    logic out_reg;

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            hist_reg <= '0;
        end else begin
            hist_reg <= {hist_reg[SAMPLES-2:0], din_i};
        end
    end

    // clock_i sampling keeps the delay independent of the prescaler
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            out_reg <= 1'b0;
        end else if (!enable_i) begin
            out_reg <= din_i;
        end else if (&hist_reg) begin
            out_reg <= 1'b1;
        end else if (~|hist_reg) begin
            out_reg <= 1'b0;
        end
    end

    assign dout_o = out_reg;

    property p_filt_agree;
        @(posedge clock_i) disable iff (!arst_n_i)
        (enable_i && $past(enable_i) && out_reg != $past(out_reg))
            |-> ($past(hist_reg) == {SAMPLES{out_reg}});
    endproperty
    a_filt_agree: assert property (p_filt_agree) else $error("filter moved early");

    property p_filt_bypass;
        @(posedge clock_i) disable iff (!arst_n_i)
        !enable_i |=> (out_reg == $past(din_i));
    endproperty
    a_filt_bypass: assert property (p_filt_bypass) else $error("bypass not one flop");
endmodule

// *** core/t16cc_pkg.sv ***
// constants, control carrier and decode helpers of the timer capture/compare block
// assumes an 8-bit register file on a 32-bit Avalon-MM slave, byte offsets below
package t16cc_pkg;
    localparam int DATA_W = 32;
    localparam int ADDR_W = 6;
    localparam int CNT_W = 16;
    localparam int FILT_SAMPLES = 4;
    localparam logic [5:0] OFS_CTRL_A = 6'h00;
    localparam logic [5:0] OFS_CTRL_B = 6'h04;
    localparam logic [5:0] OFS_CTRL_C = 6'h08;
    localparam logic [5:0] OFS_CAP_LO = 6'h0c;
    localparam logic [5:0] OFS_CAP_HI = 6'h10;
    localparam logic [5:0] OFS_CMPA_LO = 6'h14;
    localparam logic [5:0] OFS_CMPA_HI = 6'h18;
    localparam logic [5:0] OFS_CMPB_LO = 6'h1c;
    localparam logic [5:0] OFS_CMPB_HI = 6'h20;
    localparam logic [5:0] OFS_FLAGS = 6'h24;
    localparam logic [5:0] OFS_MASK = 6'h28;
    localparam logic [5:0] OFS_CMP_CTRL = 6'h2c;
    localparam logic [5:0] OFS_OUT_STAT = 6'h30;
    localparam int CA_ACT_A = 6;
    localparam int CA_ACT_B = 4;
    localparam int CA_WGM_LO = 0;
    localparam int CB_FILT_EN = 7;
    localparam int CB_EDGE_RISE = 6;
    localparam int CB_WGM_HI = 3;
    localparam int CC_FORCE_A = 7;
    localparam int CC_FORCE_B = 6;
    localparam int FL_CAP = 0;
    localparam int FL_CMP_A = 1;
    localparam int FL_CMP_B = 2;
    localparam int CS_CAP_SEL = 0;
    localparam logic [7:0] REG_RST = 8'h00;
    localparam logic [15:0] VAL_RST = 16'h0000;
    localparam logic [15:0] TOP_8BIT = 16'h00ff;
    localparam logic [15:0] TOP_9BIT = 16'h01ff;
    localparam logic [15:0] TOP_10BIT = 16'h03ff;
    localparam logic [15:0] TOP_MAX = 16'hffff;

    typedef struct packed {
        logic [1:0] action;
        logic pwm;
        logic upd;
        logic tick;
        logic blk;
        logic frc;
    } t16cc_chan_ctl_t;

    // normal, both clear-on-match modes and the reserved code run unbuffered
    function automatic logic is_pwm(input logic [3:0] wgm);
        is_pwm = !(wgm inside {4'h0, 4'h4, 4'hc, 4'hd});
    endfunction

    function automatic logic cap_is_top(input logic [3:0] wgm);
        cap_is_top = wgm inside {4'h8, 4'ha, 4'hc, 4'he};
    endfunction

    function automatic logic upd_at_bottom(input logic [3:0] wgm);
        upd_at_bottom = wgm inside {4'h8, 4'h9};
    endfunction

    function automatic logic apply_action(input logic [1:0] act, input logic cur);
        unique case (act)
            2'h1: apply_action = ~cur;
            2'h2: apply_action = 1'b0;
            2'h3: apply_action = 1'b1;
            default: apply_action = cur;
        endcase
    endfunction
endpackage

// *** core/t16cc_top.sv ***
// capture front end and two compare channels of a 16-bit timer
// assumes counter, prescaler and pin muxing live outside; one wait state per access
//
// Behaviour
// - trigger is pin unless comparator select set
// - source switch may capture; software clears flag
// - filter adds four clocks before capture
// - edge detect off when capture sets top
// - pin sampled whoever drives it
// - filter output moves after four agreeing samples
// - control B bit enables filter, else bypass
// - filter runs on system clock only
// - each capture overwrites the capture value
// - 16-bit match sets flag next tick
// - flag with enable requests irq; ack/w1c clears
// - channel A value can set counter top
// - PWM modes buffer compare, load at top/bottom
// - CPU writes buffer when buffered, else active
// - compare regs CPU-only; high byte direct read
// - high byte latched, low write loads all
// - force updates output in non-PWM modes only, no flag, no counter
// - counter write blocks next tick's matches
// - output bit kept across mode change
// - action bits act immediately, unbuffered
// - capture copies counter and sets flag together
//
// The placing of the registers and register access over Avalon-MM were decided locally.
`timescale 1ns/10ps
module t16cc_top (
    input wire logic clock_i,
    input wire logic arst_n_i,
    input wire logic [5:0] address_i,
    input wire logic read_i,
    input wire logic write_i,
    input wire logic [31:0] writedata_i,
    input wire logic [3:0] byteenable_i,
    output logic [31:0] readdata_o,
    output logic waitrequest_o,
    input wire logic capture_input_pin_i,
    input wire logic comparator_output_i,
    input wire logic [15:0] counter_value_i,
    input wire logic timer_tick_i,
    input wire logic counter_top_i,
    input wire logic counter_bottom_i,
    input wire logic counter_write_i,
    input wire logic capture_irq_ack_i,
    input wire logic [1:0] compare_irq_ack_i,
    output logic capture_irq_o,
    output logic [1:0] compare_irq_o,
    output logic [1:0] compare_output_bit_o,
    output logic [15:0] top_value_o,
    output logic [3:0] waveform_mode_sel_o
);
    logic [7:0] timer_ctrl_a_reg;
    logic [7:0] timer_ctrl_b_reg;
    logic [7:0] comparator_ctrl_status_reg;
    logic [7:0] timer_irq_mask_reg;
    logic [7:0] temp_reg;
    logic [15:0] capture_value_reg;
    logic capture_flag_reg;
    logic wait_reg;
    logic [31:0] readdata_reg;
    logic capture_irq_reg;
    logic [1:0] compare_irq_reg;
    logic [15:0] top_reg;
    logic pin_meta_reg;
    logic pin_sync_reg;
    logic cmp_meta_reg;
    logic cmp_sync_reg;
    logic filt_d_reg;
    logic blk_reg;
    logic filt_out;
    logic trig_src;
    logic edge_hit;
    logic acc;
    logic do_op;
    logic wr_ok;
    logic rd_ok;
    logic [5:0] addr;
    logic [7:0] wd;
    logic [7:0] rd_mux;
    logic [3:0] wgm;
    logic pwm_mode;
    logic cap_sel;
    logic filt_en;
    logic edge_rise;
    logic upd;
    logic [1:0] wr_cmp;
    logic [1:0] frc;
    logic [1:0] cmp_clr;
    logic [1:0] cmp_flag;
    logic [1:0] out_bit;
    logic [15:0] cmp_val [2];
    logic [15:0] cmp_act [2];
    logic cap_wr;
    logic flags_w1c;
    t16cc_pkg::t16cc_chan_ctl_t chan_ctl [2];

    assign addr = {address_i[5:2], 2'b00};
    assign wd = writedata_i[7:0];
    assign wgm = {timer_ctrl_b_reg[t16cc_pkg::CB_WGM_HI+1:t16cc_pkg::CB_WGM_HI],
                  timer_ctrl_a_reg[t16cc_pkg::CA_WGM_LO+1:t16cc_pkg::CA_WGM_LO]};
    assign pwm_mode = t16cc_pkg::is_pwm(wgm);
    assign cap_sel = comparator_ctrl_status_reg[t16cc_pkg::CS_CAP_SEL];
    assign filt_en = timer_ctrl_b_reg[t16cc_pkg::CB_FILT_EN];
    assign edge_rise = timer_ctrl_b_reg[t16cc_pkg::CB_EDGE_RISE];

    // bus handshake: first cycle of a request raises the answer, second completes it
    assign acc = (read_i || write_i) && wait_reg;
    assign do_op = (read_i || write_i) && !wait_reg;
    assign wr_ok = do_op && write_i && byteenable_i[0];
    assign rd_ok = do_op && read_i;

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            wait_reg <= 1'b1;
        end else begin
            wait_reg <= !acc;
        end
    end

    always_comb begin
        unique case (addr)
            t16cc_pkg::OFS_CTRL_A: rd_mux = timer_ctrl_a_reg;
            t16cc_pkg::OFS_CTRL_B: rd_mux = timer_ctrl_b_reg;
            t16cc_pkg::OFS_CAP_LO: rd_mux = capture_value_reg[7:0];
            t16cc_pkg::OFS_CAP_HI: rd_mux = temp_reg;
            t16cc_pkg::OFS_CMPA_LO: rd_mux = cmp_val[0][7:0];
            t16cc_pkg::OFS_CMPA_HI: rd_mux = cmp_val[0][15:8];
            t16cc_pkg::OFS_CMPB_LO: rd_mux = cmp_val[1][7:0];
            t16cc_pkg::OFS_CMPB_HI: rd_mux = cmp_val[1][15:8];
            t16cc_pkg::OFS_FLAGS: rd_mux = {5'h00, cmp_flag, capture_flag_reg};
            t16cc_pkg::OFS_MASK: rd_mux = timer_irq_mask_reg;
            t16cc_pkg::OFS_CMP_CTRL: rd_mux = comparator_ctrl_status_reg;
            t16cc_pkg::OFS_OUT_STAT: rd_mux = {6'h00, out_bit};
            default: rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            readdata_reg <= 32'h00000000;
        end else if (acc) begin
            readdata_reg <= {24'h000000, rd_mux};
        end
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            timer_ctrl_a_reg <= t16cc_pkg::REG_RST;
            timer_ctrl_b_reg <= t16cc_pkg::REG_RST;
            timer_irq_mask_reg <= t16cc_pkg::REG_RST;
            comparator_ctrl_status_reg <= t16cc_pkg::REG_RST;
        end else if (wr_ok) begin
            if (addr == t16cc_pkg::OFS_CTRL_A) begin
                timer_ctrl_a_reg <= wd;
            end
            if (addr == t16cc_pkg::OFS_CTRL_B) begin
                timer_ctrl_b_reg <= wd;
            end
            if (addr == t16cc_pkg::OFS_MASK) begin
                timer_irq_mask_reg <= wd;
            end
            if (addr == t16cc_pkg::OFS_CMP_CTRL) begin
                comparator_ctrl_status_reg <= wd;
            end
        end
    end

    // shared high-byte latch: filled by high writes and by capture low reads
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            temp_reg <= t16cc_pkg::REG_RST;
        end else if (wr_ok && (addr == t16cc_pkg::OFS_CAP_HI || addr == t16cc_pkg::OFS_CMPA_HI
                               || addr == t16cc_pkg::OFS_CMPB_HI)) begin
            temp_reg <= wd;
        end else if (rd_ok && addr == t16cc_pkg::OFS_CAP_LO) begin
            temp_reg <= capture_value_reg[15:8];
        end
    end

    // pin is sampled as a pin, so port-driven levels capture too
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pin_meta_reg <= 1'b0;
            pin_sync_reg <= 1'b0;
            cmp_meta_reg <= 1'b0;
            cmp_sync_reg <= 1'b0;
        end else begin
            pin_meta_reg <= capture_input_pin_i;
            pin_sync_reg <= pin_meta_reg;
            cmp_meta_reg <= comparator_output_i;
            cmp_sync_reg <= cmp_meta_reg;
        end
    end

    // switching source can look like an edge; software discards it
    assign trig_src = cap_sel ? cmp_sync_reg : pin_sync_reg;

    t16cc_noise_filter #(
        .SAMPLES(t16cc_pkg::FILT_SAMPLES)
    ) u_filter (
        .clock_i(clock_i),
        .arst_n_i(arst_n_i),
        .din_i(trig_src),
        .enable_i(filt_en),
        .dout_o(filt_out)
    );

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            filt_d_reg <= 1'b0;
        end else begin
            filt_d_reg <= filt_out;
        end
    end

    assign edge_hit = !t16cc_pkg::cap_is_top(wgm)
                      && (edge_rise ? (filt_out && !filt_d_reg) : (!filt_out && filt_d_reg));
    assign cap_wr = wr_ok && addr == t16cc_pkg::OFS_CAP_LO && t16cc_pkg::cap_is_top(wgm);

    // no read-pending guard: a fresh event always wins
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            capture_value_reg <= t16cc_pkg::VAL_RST;
        end else if (edge_hit) begin
            capture_value_reg <= counter_value_i;
        end else if (cap_wr) begin
            capture_value_reg <= {temp_reg, wd};
        end
    end

    assign flags_w1c = wr_ok && addr == t16cc_pkg::OFS_FLAGS;

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            capture_flag_reg <= 1'b0;
        end else if (edge_hit) begin
            capture_flag_reg <= 1'b1;
        end else if ((flags_w1c && wd[t16cc_pkg::FL_CAP]) || capture_irq_ack_i) begin
            capture_flag_reg <= 1'b0;
        end
    end

    // a counter write holds its block until the next tick consumes it
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            blk_reg <= 1'b0;
        end else begin
            blk_reg <= counter_write_i || (blk_reg && !timer_tick_i);
        end
    end

    assign upd = timer_tick_i
                 && (t16cc_pkg::upd_at_bottom(wgm) ? counter_bottom_i : counter_top_i);
    assign wr_cmp[0] = wr_ok && addr == t16cc_pkg::OFS_CMPA_LO;
    assign wr_cmp[1] = wr_ok && addr == t16cc_pkg::OFS_CMPB_LO;
    assign frc[0] = wr_ok && addr == t16cc_pkg::OFS_CTRL_C && wd[t16cc_pkg::CC_FORCE_A];
    assign frc[1] = wr_ok && addr == t16cc_pkg::OFS_CTRL_C && wd[t16cc_pkg::CC_FORCE_B];
    assign cmp_clr[0] = (flags_w1c && wd[t16cc_pkg::FL_CMP_A]) || compare_irq_ack_i[0];
    assign cmp_clr[1] = (flags_w1c && wd[t16cc_pkg::FL_CMP_B]) || compare_irq_ack_i[1];

    always_comb begin
        for (int i = 0; i < 2; i++) begin
            chan_ctl[i].pwm = pwm_mode;
            chan_ctl[i].upd = upd;
            chan_ctl[i].tick = timer_tick_i;
            chan_ctl[i].blk = blk_reg;
            chan_ctl[i].frc = frc[i];
        end
        chan_ctl[0].action = timer_ctrl_a_reg[t16cc_pkg::CA_ACT_A+1:t16cc_pkg::CA_ACT_A];
        chan_ctl[1].action = timer_ctrl_a_reg[t16cc_pkg::CA_ACT_B+1:t16cc_pkg::CA_ACT_B];
    end

    for (genvar g = 0; g < 2; g++) begin : g_chan
        t16cc_compare_chan u_chan (
            .clock_i(clock_i),
            .arst_n_i(arst_n_i),
            .ctl_i(chan_ctl[g]),
            .counter_i(counter_value_i),
            .wr_i(wr_cmp[g]),
            .wr_data_i({temp_reg, wd}),
            .flag_clr_i(cmp_clr[g]),
            .value_o(cmp_val[g]),
            .active_o(cmp_act[g]),
            .flag_o(cmp_flag[g]),
            .out_bit_o(out_bit[g])
        );
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            capture_irq_reg <= 1'b0;
            compare_irq_reg <= 2'b00;
        end else begin
            capture_irq_reg <= capture_flag_reg && timer_irq_mask_reg[t16cc_pkg::FL_CAP];
            compare_irq_reg <= cmp_flag
                    & timer_irq_mask_reg[t16cc_pkg::FL_CMP_B:t16cc_pkg::FL_CMP_A];
        end
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            top_reg <= t16cc_pkg::TOP_MAX;
        end else begin
            unique case (wgm)
                4'h1, 4'h5: top_reg <= t16cc_pkg::TOP_8BIT;
                4'h2, 4'h6: top_reg <= t16cc_pkg::TOP_9BIT;
                4'h3, 4'h7: top_reg <= t16cc_pkg::TOP_10BIT;
                4'h4, 4'h9, 4'hb, 4'hf: top_reg <= cmp_act[0];
                4'h8, 4'ha, 4'hc, 4'he: top_reg <= capture_value_reg;
                default: top_reg <= t16cc_pkg::TOP_MAX;
            endcase
        end
    end

    assign readdata_o = readdata_reg;
    assign waitrequest_o = wait_reg;
    assign capture_irq_o = capture_irq_reg;
    assign compare_irq_o = compare_irq_reg;
    assign compare_output_bit_o = out_bit;
    assign top_value_o = top_reg;
    assign waveform_mode_sel_o = wgm;

    property p_cap_copy;
        @(posedge clock_i) disable iff (!arst_n_i)
        edge_hit |=> (capture_value_reg == $past(counter_value_i)) && capture_flag_reg;
    endproperty
    a_cap_copy: assert property (p_cap_copy) else $error("capture not taken with flag");

    property p_cap_top_hold;
        @(posedge clock_i) disable iff (!arst_n_i)
        (t16cc_pkg::cap_is_top(wgm) && !cap_wr) |=> $stable(capture_value_reg);
    endproperty
    a_cap_top_hold: assert property (p_cap_top_hold) else $error("capture in top mode");
endmodule

// *** test/t16cc_timer_model.sv ***
// model of the outside counter and its prescaled timer clock
// assumes the bench commands run and load; one tick every fourth system clock
`timescale 1ns/10ps
module t16cc_timer_model (
    input wire logic clock_i,
    input wire logic arst_n_i,
    input wire logic run_i,
    input wire logic load_i,
    input wire logic [15:0] load_val_i,
    input wire logic [15:0] top_val_i,
    output logic [15:0] count_o,
    output logic tick_o,
    output logic top_o,
    output logic bottom_o,
    output logic cnt_wr_o
);
    logic [1:0] div_reg;
    assign top_o = count_o == top_val_i;
    assign bottom_o = count_o == 16'h0000;
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            div_reg <= 2'h0;
            tick_o <= 1'b0;
            count_o <= 16'h0000;
            cnt_wr_o <= 1'b0;
        end else begin
            // prescaler stalls with the counter, so a stopped timer gives no tick
            div_reg <= run_i ? div_reg + 2'h1 : div_reg;
            tick_o <= run_i && div_reg == 2'h3;
            cnt_wr_o <= load_i;
            // load wins over counting; the bench never loads top or bottom here
            if (load_i) begin
                count_o <= load_val_i;
            end else if (tick_o) begin
                count_o <= top_o ? 16'h0000 : count_o + 16'h0001;
            end
        end
    end
endmodule

// *** test/timer16_capture_compare_test.sv ***
// self-checking bench of the capture/compare block with a counter model
// assumes an Avalon slave with waitrequest and the package register map
`timescale 1ns/10ps
module timer16_capture_compare_test;
    logic clock_i = 0, arst_n_i = 0, read_i = 0, write_i = 0, pin = 0, cmp_out = 0;
    logic run = 0, load = 0, ack = 0, waitrequest_o, tick, top, bottom, cnt_wr, cap_irq;
    logic [5:0] address_i = 6'h00;
    logic [31:0] writedata_i = 32'h0, readdata_o, rdata;
    logic [15:0] load_val = 16'h0, cnt, top_v, r, v;
    logic [1:0] cmp_irq, out_bits;
    logic [3:0] mode;
    integer mismatches = 0, num_checks = 0, seed = 32'h28e815e1, i;
    always #4 clock_i = ~clock_i;
    t16cc_top dut (.clock_i(clock_i), .arst_n_i(arst_n_i), .address_i(address_i),
        .read_i(read_i), .write_i(write_i), .writedata_i(writedata_i), .byteenable_i(4'hf),
        .readdata_o(readdata_o), .waitrequest_o(waitrequest_o), .capture_input_pin_i(pin),
        .comparator_output_i(cmp_out), .counter_value_i(cnt), .timer_tick_i(tick),
        .counter_top_i(top), .counter_bottom_i(bottom), .counter_write_i(cnt_wr),
        .capture_irq_ack_i(ack), .compare_irq_ack_i({2{ack}}), .capture_irq_o(cap_irq),
        .compare_irq_o(cmp_irq), .compare_output_bit_o(out_bits), .top_value_o(top_v),
        .waveform_mode_sel_o(mode));
    t16cc_timer_model partner (.clock_i(clock_i), .arst_n_i(arst_n_i), .run_i(run),
        .load_i(load), .load_val_i(load_val), .top_val_i(top_v), .count_o(cnt),
        .tick_o(tick), .top_o(top), .bottom_o(bottom), .cnt_wr_o(cnt_wr));
    task complete_run;
        if (mismatches == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask
    // request held through the edge that samples waitrequest low
    task bus(input logic we, input logic [5:0] a, input logic [7:0] d);
        integer n;
        @(posedge clock_i);
        read_i <= !we;
        write_i <= we;
        address_i <= a;
        writedata_i <= {24'h0, d};
        @(posedge clock_i);
        for (n = 0; n < 20 && waitrequest_o !== 1'b0; n++) @(posedge clock_i);
        if (n == 20) begin
            mismatches++;
            complete_run;
        end
        rdata = readdata_o;
        read_i <= 1'b0;
        write_i <= 1'b0;
    endtask
    task rchk(input string what, input logic [5:0] a, input logic [7:0] exp);
        bus(1'b0, a, 8'h00);
        chk(what, {8'h00, exp}, rdata[15:0]);
    endtask
    task ld(input logic [15:0] val);
        @(posedge clock_i);
        load <= 1'b1;
        load_val <= val;
        @(posedge clock_i);
        load <= 1'b0;
    endtask
    initial begin
        repeat (16) @(posedge clock_i);
        arst_n_i <= 1'b1;
        for (i = 0; i < 14; i++) rchk("reset value", 6'(i * 4), t16cc_pkg::REG_RST);
        chk("top", t16cc_pkg::TOP_MAX, top_v);
        r = 16'h1000 | 16'($random(seed) & 16'h0fff);
        bus(1'b1, t16cc_pkg::OFS_MASK, 8'h03);
        bus(1'b1, t16cc_pkg::OFS_CTRL_A, 8'h40);
        bus(1'b1, t16cc_pkg::OFS_CMPA_HI, r[15:8]);
        bus(1'b1, t16cc_pkg::OFS_CMPA_LO, r[7:0]);
        rchk("cmp lo", t16cc_pkg::OFS_CMPA_LO, r[7:0]);
        rchk("cmp hi", t16cc_pkg::OFS_CMPA_HI, r[15:8]);
        ld(r - 16'h0003);
        run <= 1'b1;
        repeat (40) @(posedge clock_i);
        run <= 1'b0;
        rchk("flags", t16cc_pkg::OFS_FLAGS, 8'h02);
        rchk("outputs", t16cc_pkg::OFS_OUT_STAT, 8'h01);
        chk("cmp irq", 16'h0001, {14'h0, cmp_irq});
        bus(1'b1, t16cc_pkg::OFS_FLAGS, 8'h02);
        repeat (2) @(posedge clock_i);
        chk("cmp irq", 16'h0000, {14'h0, cmp_irq});
        ld(r);
        run <= 1'b1;
        repeat (6) @(posedge clock_i);
        run <= 1'b0;
        rchk("flags", t16cc_pkg::OFS_FLAGS, 8'h00);
        bus(1'b1, t16cc_pkg::OFS_CTRL_A, 8'h70);
        bus(1'b1, t16cc_pkg::OFS_CTRL_C, 8'h40);
        rchk("outputs", t16cc_pkg::OFS_OUT_STAT, 8'h03);
        rchk("flags", t16cc_pkg::OFS_FLAGS, 8'h00);
        v = 16'($random(seed));
        ld(v);
        bus(1'b1, t16cc_pkg::OFS_CTRL_B, 8'h40);
        bus(1'b1, t16cc_pkg::OFS_FLAGS, 8'h01);
        pin <= 1'b1;
        repeat (10) @(posedge clock_i);
        rchk("flags", t16cc_pkg::OFS_FLAGS, 8'h01);
        chk("cap irq", 16'h0001, {15'h0, cap_irq});
        rchk("cap lo", t16cc_pkg::OFS_CAP_LO, v[7:0]);
        rchk("cap hi", t16cc_pkg::OFS_CAP_HI, v[15:8]);
        ack <= 1'b1;
        @(posedge clock_i);
        ack <= 1'b0;
        rchk("flags", t16cc_pkg::OFS_FLAGS, 8'h00);
        pin <= 1'b0;
        ld(v ^ 16'h5a5a);
        repeat (10) @(posedge clock_i);
        pin <= 1'b1;
        repeat (10) @(posedge clock_i);
        rchk("cap lo", t16cc_pkg::OFS_CAP_LO, v[7:0] ^ 8'h5a);
        bus(1'b1, t16cc_pkg::OFS_CTRL_B, 8'hc0);
        bus(1'b1, t16cc_pkg::OFS_FLAGS, 8'h01);
        pin <= 1'b0;
        repeat (3) @(posedge clock_i);
        pin <= 1'b1;
        repeat (12) @(posedge clock_i);
        rchk("flags", t16cc_pkg::OFS_FLAGS, 8'h00);
        pin <= 1'b0;
        repeat (12) @(posedge clock_i);
        pin <= 1'b1;
        repeat (4) @(posedge clock_i);
        rchk("flags", t16cc_pkg::OFS_FLAGS, 8'h00);
        repeat (8) @(posedge clock_i);
        rchk("flags", t16cc_pkg::OFS_FLAGS, 8'h01);
        bus(1'b1, t16cc_pkg::OFS_CMP_CTRL, 8'h01);
        bus(1'b1, t16cc_pkg::OFS_FLAGS, 8'h01);
        cmp_out <= 1'b1;
        repeat (14) @(posedge clock_i);
        rchk("flags", t16cc_pkg::OFS_FLAGS, 8'h01);
        bus(1'b1, t16cc_pkg::OFS_CTRL_A, 8'h71);
        rchk("outputs", t16cc_pkg::OFS_OUT_STAT, 8'h03);
        chk("top", t16cc_pkg::TOP_8BIT, top_v);
        chk("mode", 16'h0001, {12'h0, mode});
        chk("out bits", 16'h0003, {14'h0, out_bits});
        bus(1'b1, t16cc_pkg::OFS_CTRL_B, 8'hd8);
        bus(1'b1, t16cc_pkg::OFS_CTRL_A, 8'h73);
        bus(1'b1, t16cc_pkg::OFS_CMPA_HI, r[15:8] ^ 8'h0f);
        bus(1'b1, t16cc_pkg::OFS_CMPA_LO, r[7:0]);
        chk("top", r, top_v);
        ld(r - 16'h0001);
        run <= 1'b1;
        repeat (12) @(posedge clock_i);
        chk("top", r ^ 16'h0f00, top_v);
        complete_run;
    end
endmodule
